// ==== dwc_pkg.sv ====
package dwc_pkg;
   // ==========================================================
   // Clock, memory and latency
   localparam int unsigned CLK_HZ = 40_000_000; // System clock, 25 ns period
   localparam int unsigned MEM_BYTES = 2_097_152; // Acquisition memory size
   localparam int unsigned MEM_WORDS = MEM_BYTES / 4; // 32-bit words held
   localparam int ADDR_W = 19; // Word address, wraps at MEM_WORDS
   localparam int CNT_W = 20; // Sample counters
   localparam int TRIG_LAG_MAX = 8; // Worst trigger-in to trigger-out lag

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_POST = 8'h08;
   localparam logic [7:0] OFF_TRIG_ADDR = 8'h0c;
   localparam logic [7:0] OFF_WR_ADDR = 8'h10;
   localparam logic [7:0] OFF_INT_STAT = 8'h14;
   localparam logic [7:0] OFF_INT_MASK = 8'h18;
   localparam logic [7:0] OFF_INT_DIV = 8'h1c;
   localparam logic [7:0] OFF_MEM_ADDR = 8'h20;
   localparam logic [7:0] OFF_MEM_DATA = 8'h24;
   localparam logic [7:0] OFF_DMA_SRC = 8'h28;
   localparam logic [7:0] OFF_DMA_DST = 8'h2c;
   localparam logic [7:0] OFF_DMA_LEN = 8'h30;
   localparam logic [7:0] OFF_DMA_CTRL = 8'h34;

   // ==========================================================
   // Control field positions
   localparam int CB_ARM = 0; // Write 1: arm a new capture
   localparam int CB_SOFT = 1; // Write 1: software trigger
   localparam int CB_WIDTH = 2; // Two bits: word width code
   localparam int CB_EXT_CLK = 4; // 1: external sample clock
   localparam int CB_CLK_FALL = 5; // 1: latch on falling clock edge
   localparam int CB_TRIG_FALL = 6; // 1: trigger on falling edge
   localparam int CB_EXT_TRIG = 7; // 1: external trigger enabled
   localparam int CB_ABORT = 8; // Write 1: stop capture

   // Width codes
   localparam logic [1:0] WID_8 = 2'h0;
   localparam logic [1:0] WID_16 = 2'h1;
   localparam logic [1:0] WID_32 = 2'h2;

   // Interrupt bits
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_DMA = 2;

   // ==========================================================
   // Reset values
   localparam logic [1:0] WIDTH_RST = WID_8;
   localparam logic [CNT_W-1:0] POST_RST = 20'h00100;
   localparam logic [15:0] DIV_RST = 16'h0003;
   localparam logic [2:0] MASK_RST = 3'h0;

   // Post-trigger minimum and step per width
   localparam logic [CNT_W-1:0] POST_MIN_8 = 20'h00100;
   localparam logic [CNT_W-1:0] POST_STEP_8 = 20'h00080;
   localparam logic [CNT_W-1:0] POST_MIN_16 = 20'h00080;
   localparam logic [CNT_W-1:0] POST_STEP_16 = 20'h00040;
   localparam logic [CNT_W-1:0] POST_MIN_32 = 20'h00040;
   localparam logic [CNT_W-1:0] POST_STEP_32 = 20'h00020;

   // Raise to the minimum, then round down to the step
   function automatic logic [CNT_W-1:0] post_eff(input logic [1:0] w,
                                                 input logic [CNT_W-1:0] req);
      logic [CNT_W-1:0] mn;
      logic [CNT_W-1:0] st;
      mn = (w == WID_8) ? POST_MIN_8 : (w == WID_16) ? POST_MIN_16 : POST_MIN_32;
      st = (w == WID_8) ? POST_STEP_8 : (w == WID_16) ? POST_STEP_16 : POST_STEP_32;
      return (req < mn) ? mn : (req & ~(st - 20'h00001));
   endfunction
endpackage

// ==== dwc_edge_sync.sv ====
// ==========================================================
// Two-flop synchroniser with edge detection behind it
module dwc_edge_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Asynchronous pin
   input wire logic pin,
   // Edge pulses of the synchronised level
   output logic rise,
   output logic fall
);
   logic s1_r; // First stage, read only by s2_r
   logic s2_r; // Safe level
   logic s3_r; // Previous safe level

   // Edges look only at the second and third stages
   assign rise = s2_r & ~s3_r;
   assign fall = ~s2_r & s3_r;

   // Sampling chain
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
endmodule

// ==== dwc_packer.sv ====
// ==========================================================
// Packs 8, 16 or 32 bit samples into 32-bit words
module dwc_packer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic clear,
   input wire logic [1:0] width,
   // Samples
   input wire logic stb,
   input wire logic [31:0] din,
   // Packed words
   output logic word_valid,
   output logic [31:0] word
);
   logic [1:0] cnt_r; // Lane of the next sample
   logic [31:0] acc_r; // Partly filled word
   logic word_valid_r;
   logic [31:0] word_r;

   // Lane placement, first sample lands in the low bits
   wire [1:0] last = (width == dwc_pkg::WID_8) ? 2'h3 :
                     (width == dwc_pkg::WID_16) ? 2'h1 : 2'h0;
   wire [31:0] lane8 = {24'h000000, din[7:0]} << {cnt_r, 3'h0};
   wire [31:0] lane16 = {16'h0000, din[15:0]} << {cnt_r[0], 4'h0};
   wire [31:0] merged = (width == dwc_pkg::WID_8) ? (acc_r | lane8) :
                        (width == dwc_pkg::WID_16) ? (acc_r | lane16) : din;
   wire full = stb && (cnt_r == last);

   assign word_valid = word_valid_r;
   assign word = word_r;

   // Accumulate and emit
   always_ff @(posedge clk) begin
      if (reset || clear) begin
         cnt_r <= 2'h0;
         acc_r <= 32'h00000000;
         word_valid_r <= 1'b0;
         word_r <= 32'h00000000;
      end else begin
         word_valid_r <= full;
         if (full) begin
            word_r <= merged;
            acc_r <= 32'h00000000;
            cnt_r <= 2'h0;
         end else if (stb) begin
            acc_r <= merged;
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end
endmodule

// ==== dwc_capture.sv ====
// Function
// RULE1: Word width selectable as 8, 16, 32
// RULE2: Narrow widths pack more samples per memory
// RULE3: Memory written circularly, address wraps continuously
// RULE4: Armed capture waits for trigger without timeout
// RULE5: Latch on clock edge, demultiplex into words
// RULE6: Sample clock internal oscillator or external line
// RULE7: Rising or falling clock edge selectable
// RULE8: External clock never faster than 100 MHz; sampled on the 40 MHz system clock, edges are caught only below 20 MHz
// RULE9: External clock may stop; store real edges
// RULE10: External trigger on selectable rising/falling edge
// RULE11: Trigger out synchronous, within 8 cycles
// RULE12: Host reads acquisition memory over bus
// RULE13: Bus-master DMA of captured words to host
// RULE14: Post-trigger count obeys width minimum, step
// RULE15: Trigger from external input or software
// RULE16: Narrow samples packed in arrival order
// RULE17: Count post samples, stop, record trigger address
module dwc_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // User logic pins
   input wire logic [31:0] cap_data,
   input wire logic cap_clk,
   input wire logic cap_trig,
   output logic trig_out,
   // Interrupt
   output logic irq,
   // DMA master port
   output logic dma_req,
   output logic [31:0] dma_addr,
   output logic [31:0] dma_wdata,
   input wire logic dma_ack
);
   // ==========================================================
   // Declarations
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_POST} dwc_state_t;
   dwc_state_t state_r; // Capture phase
   dwc_state_t state_nxt;
   logic [31:0] mem [dwc_pkg::MEM_WORDS]; // Acquisition memory
   logic [31:0] d1_r; // Data sync, first stage
   logic [31:0] d2_r; // Data sync, safe stage
   logic [1:0] width_r; // Width code
   logic ext_clk_r; // External clock select
   logic clk_fall_r; // Falling clock edge select
   logic trig_fall_r; // Falling trigger edge select
   logic ext_trig_r; // External trigger enable
   logic [dwc_pkg::CNT_W-1:0] post_r; // Requested post count
   logic [15:0] div_r; // Internal oscillator divider
   logic [15:0] div_cnt_r;
   logic [2:0] mask_r; // Interrupt mask
   logic [2:0] stat_r; // Sticky interrupt status
   logic [2:0] stat_nxt;
   logic [dwc_pkg::ADDR_W-1:0] wr_addr_r; // Next word to write
   logic [dwc_pkg::ADDR_W-1:0] trig_addr_r; // Write address at trigger
   logic [dwc_pkg::CNT_W-1:0] remain_r; // Post samples still due
   logic triggered_r;
   logic done_r;
   logic trig_out_r;
   logic [31:0] rdata_r;
   logic [dwc_pkg::ADDR_W-1:0] mem_ptr_r; // Host read pointer
   logic [dwc_pkg::ADDR_W-1:0] dma_src_r;
   logic [31:0] dma_dst_r;
   logic [dwc_pkg::CNT_W-1:0] dma_len_r;
   logic dma_busy_r;
   logic dma_req_r;
   logic [31:0] dma_wdata_r;
   logic eclk_rise;
   logic eclk_fall;
   logic etrig_rise;
   logic etrig_fall;
   logic word_valid;
   logic [31:0] word;

   // ==========================================================
   // Pin synchronisers
   dwc_edge_sync u_clk_sync (
      .clk(clk),
      .reset(reset),
      .pin(cap_clk),
      .rise(eclk_rise),
      .fall(eclk_fall)
   );
   dwc_edge_sync u_trig_sync (
      .clk(clk),
      .reset(reset),
      .pin(cap_trig),
      .rise(etrig_rise),
      .fall(etrig_fall)
   );

   // Data passes two flops, aligned with the clock edge detect
   always_ff @(posedge clk) begin
      if (reset) begin
         d1_r <= 32'h00000000;
         d2_r <= 32'h00000000;
      end else begin
         d1_r <= cap_data;
         d2_r <= d1_r;
      end
   end

   // ==========================================================
   // Register decode
   wire wr_ctrl = reg_wr && (reg_addr == dwc_pkg::OFF_CTRL);
   wire arm = wr_ctrl && reg_wdata[dwc_pkg::CB_ARM];
   wire soft_trig = wr_ctrl && reg_wdata[dwc_pkg::CB_SOFT];
   wire abort = wr_ctrl && reg_wdata[dwc_pkg::CB_ABORT];
   wire rd_stat = reg_rd && (reg_addr == dwc_pkg::OFF_INT_STAT);
   wire rd_mem = reg_rd && (reg_addr == dwc_pkg::OFF_MEM_DATA);
   wire dma_go = reg_wr && (reg_addr == dwc_pkg::OFF_DMA_CTRL) && reg_wdata[0] &&
                 !dma_busy_r && (dma_len_r != 20'h00000);

   // ==========================================================
   // Sample strobe and trigger selection
   wire int_tick = (div_cnt_r == div_r);
   wire ext_edge = clk_fall_r ? eclk_fall : eclk_rise; // RULE7
   // Only real edges count, so a stopped clock stores nothing
   wire sample_stb = ext_clk_r ? ext_edge : int_tick; // RULE6 RULE9
   wire writing = (state_r != ST_IDLE);
   wire pack_stb = sample_stb && writing;
   wire trig_edge = ext_trig_r && (trig_fall_r ? etrig_fall : etrig_rise); // RULE10
   wire trig_fire = (state_r == ST_ARMED) && (soft_trig || trig_edge); // RULE15
   wire cap_done = (state_r == ST_POST) && (remain_r == 20'h00000) && word_valid;
   wire word_write = word_valid && writing;
   wire [dwc_pkg::CNT_W-1:0] post_now = dwc_pkg::post_eff(width_r, post_r); // RULE14
   wire dma_beat = dma_req_r && dma_ack;
   wire dma_last = dma_beat && (dma_len_r == 20'h00001);
   wire [2:0] events = {dma_last, cap_done, trig_fire};

   // ==========================================================
   // Packing of narrow samples into memory words
   dwc_packer u_packer (
      .clk(clk),
      .reset(reset),
      .clear(arm),
      .width(width_r),
      .stb(pack_stb),
      .din(d2_r),
      .word_valid(word_valid),
      .word(word)
   );
   // Internal oscillator divider
   always_ff @(posedge clk) begin
      if (reset || int_tick) div_cnt_r <= 16'h0000;
      else div_cnt_r <= div_cnt_r + 16'h0001;
   end

   // ==========================================================
   // Capture sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (arm) state_nxt = ST_ARMED;
         end
         ST_ARMED: begin
            // No timeout: stays here until a trigger or abort
            if (abort) state_nxt = ST_IDLE; // RULE4
            else if (trig_fire) state_nxt = ST_POST;
         end
         ST_POST: begin
            if (abort || cap_done) state_nxt = ST_IDLE; // RULE17
         end
         default: state_nxt = ST_IDLE;
      endcase
   end
   // State register
   always_ff @(posedge clk) begin
      if (reset) state_r <= ST_IDLE;
      else state_r <= state_nxt;
   end

   // Post-trigger counter, loaded with the legal count
   always_ff @(posedge clk) begin
      if (reset) remain_r <= 20'h00000;
      else if (trig_fire) remain_r <= post_now; // RULE14 RULE17
      else if (state_r == ST_POST && pack_stb && remain_r != 20'h00000)
         remain_r <= remain_r - 20'h00001;
   end

   // Circular write; 19 bits wrap exactly at the memory end
   always_ff @(posedge clk) begin
      if (reset || arm) wr_addr_r <= '0;
      else if (word_write) wr_addr_r <= wr_addr_r + 19'h00001; // RULE3 RULE2
   end
   // Memory write port
   always_ff @(posedge clk) begin
      if (word_write) mem[wr_addr_r] <= word; // RULE5 RULE16
   end

   // Trigger address, flags and trigger output
   always_ff @(posedge clk) begin
      if (reset) begin
         trig_addr_r <= '0;
         triggered_r <= 1'b0;
         done_r <= 1'b0;
         trig_out_r <= 1'b0;
      end else if (arm) begin
         triggered_r <= 1'b0;
         done_r <= 1'b0;
         trig_out_r <= 1'b0;
      end else begin
         if (trig_fire) begin
            trig_addr_r <= wr_addr_r; // RULE17
            triggered_r <= 1'b1;
            trig_out_r <= 1'b1; // RULE11
         end
         if (cap_done) done_r <= 1'b1; // RULE17
      end
   end
   assign trig_out = trig_out_r;

   // ==========================================================
   // Software registers
   always_ff @(posedge clk) begin
      if (reset) begin
         width_r <= dwc_pkg::WIDTH_RST;
         ext_clk_r <= 1'b0;
         clk_fall_r <= 1'b0;
         trig_fall_r <= 1'b0;
         ext_trig_r <= 1'b0;
         post_r <= dwc_pkg::POST_RST;
         div_r <= dwc_pkg::DIV_RST;
         mask_r <= dwc_pkg::MASK_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            dwc_pkg::OFF_CTRL: begin
               width_r <= reg_wdata[dwc_pkg::CB_WIDTH +: 2]; // RULE1
               ext_clk_r <= reg_wdata[dwc_pkg::CB_EXT_CLK];
               clk_fall_r <= reg_wdata[dwc_pkg::CB_CLK_FALL];
               trig_fall_r <= reg_wdata[dwc_pkg::CB_TRIG_FALL];
               ext_trig_r <= reg_wdata[dwc_pkg::CB_EXT_TRIG];
            end
            dwc_pkg::OFF_POST: post_r <= reg_wdata[dwc_pkg::CNT_W-1:0];
            dwc_pkg::OFF_INT_DIV: div_r <= reg_wdata[15:0];
            dwc_pkg::OFF_INT_MASK: mask_r <= reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   // Sticky status: a new event wins over the read that clears
   assign stat_nxt = (rd_stat ? 3'h0 : stat_r) | events;
   always_ff @(posedge clk) begin
      if (reset) stat_r <= 3'h0;
      else stat_r <= stat_nxt;
   end
   assign irq = |(stat_r & mask_r);

   // Host memory pointer, advances after each data read
   always_ff @(posedge clk) begin
      if (reset) mem_ptr_r <= '0;
      else if (reg_wr && reg_addr == dwc_pkg::OFF_MEM_ADDR)
         mem_ptr_r <= reg_wdata[dwc_pkg::ADDR_W-1:0];
      else if (rd_mem) mem_ptr_r <= mem_ptr_r + 19'h00001; // RULE12
   end

   // ==========================================================
   // Read mux; unmapped offsets read as zero
   wire [31:0] rd_val =
      (reg_addr == dwc_pkg::OFF_CTRL) ? {23'h000000, 1'b0, ext_trig_r, trig_fall_r,
                                         clk_fall_r, ext_clk_r, width_r, 2'h0} :
      (reg_addr == dwc_pkg::OFF_STATUS) ? {28'h0000000, dma_busy_r, done_r,
                                           triggered_r, writing} :
      (reg_addr == dwc_pkg::OFF_POST) ? {12'h000, post_now} :
      (reg_addr == dwc_pkg::OFF_TRIG_ADDR) ? {13'h0000, trig_addr_r} :
      (reg_addr == dwc_pkg::OFF_WR_ADDR) ? {13'h0000, wr_addr_r} :
      (reg_addr == dwc_pkg::OFF_INT_STAT) ? {29'h00000000, stat_r} :
      (reg_addr == dwc_pkg::OFF_INT_MASK) ? {29'h00000000, mask_r} :
      (reg_addr == dwc_pkg::OFF_INT_DIV) ? {16'h0000, div_r} :
      (reg_addr == dwc_pkg::OFF_MEM_ADDR) ? {13'h0000, mem_ptr_r} :
      (reg_addr == dwc_pkg::OFF_MEM_DATA) ? mem[mem_ptr_r] :
      (reg_addr == dwc_pkg::OFF_DMA_SRC) ? {13'h0000, dma_src_r} :
      (reg_addr == dwc_pkg::OFF_DMA_DST) ? dma_dst_r :
      (reg_addr == dwc_pkg::OFF_DMA_LEN) ? {12'h000, dma_len_r} : 32'h00000000;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset || !reg_rd) rdata_r <= 32'h00000000;
      else rdata_r <= rd_val; // RULE12
   end
   assign reg_rdata = rdata_r;

   // ==========================================================
   // DMA engine: one word per request/acknowledge
   always_ff @(posedge clk) begin
      if (reset) begin
         dma_src_r <= '0;
         dma_dst_r <= 32'h00000000;
         dma_len_r <= 20'h00000;
         dma_busy_r <= 1'b0;
         dma_req_r <= 1'b0;
         dma_wdata_r <= 32'h00000000;
      end else if (dma_busy_r) begin
         // Setup registers are frozen while a transfer runs
         if (!dma_req_r) begin
            dma_wdata_r <= mem[dma_src_r]; // RULE13
            dma_req_r <= 1'b1;
         end else if (dma_ack) begin
            dma_req_r <= 1'b0;
            dma_src_r <= dma_src_r + 19'h00001;
            dma_dst_r <= dma_dst_r + 32'h00000004;
            dma_len_r <= dma_len_r - 20'h00001;
            if (dma_last) dma_busy_r <= 1'b0;
         end
      end else if (dma_go) begin
         dma_busy_r <= 1'b1;
      end else if (reg_wr) begin
         if (reg_addr == dwc_pkg::OFF_DMA_SRC) dma_src_r <= reg_wdata[dwc_pkg::ADDR_W-1:0];
         if (reg_addr == dwc_pkg::OFF_DMA_DST) dma_dst_r <= reg_wdata;
         if (reg_addr == dwc_pkg::OFF_DMA_LEN) dma_len_r <= reg_wdata[dwc_pkg::CNT_W-1:0];
      end
   end
   assign dma_req = dma_req_r;
   assign dma_addr = dma_dst_r;
   assign dma_wdata = dma_wdata_r;

   // ==========================================================
   // Assertions
   // A re-arm in the same cycle clears the flags, so it is left out here
   sequence s_ext_trig_armed;
      (state_r == ST_ARMED) && trig_edge && !abort && !arm;
   endsequence
   sequence s_out_rises;
      ##[1:8] trig_out;
   endsequence
   a_trig_out_lag: assert property (@(posedge clk) disable iff (reset) // RULE11
      s_ext_trig_armed |-> s_out_rises)
      else $error("Trigger output late");
   a_ext_edge_fires: assert property (@(posedge clk) disable iff (reset) // RULE10
      s_ext_trig_armed |=> (state_r == ST_POST) && triggered_r)
      else $error("External trigger edge missed");
   a_soft_trig_fires: assert property (@(posedge clk) disable iff (reset) // RULE15
      (state_r == ST_ARMED) && soft_trig && !abort |=> state_r == ST_POST)
      else $error("Software trigger missed");
   a_armed_no_timeout: assert property (@(posedge clk) disable iff (reset) // RULE4
      (state_r == ST_ARMED) && !trig_fire && !abort |=> state_r == ST_ARMED)
      else $error("Armed state left without cause");
   a_wrap_addr: assert property (@(posedge clk) disable iff (reset) // RULE3
      word_write && !arm && (&wr_addr_r) |=> wr_addr_r == '0)
      else $error("Write address did not wrap");
   a_word_stored: assert property (@(posedge clk) disable iff (reset) // RULE5
      word_write && !arm |=> wr_addr_r == $past(wr_addr_r) + 19'h00001)
      else $error("Word not advanced");
   a_real_edges: assert property (@(posedge clk) disable iff (reset) // RULE9
      word_valid |-> $past(pack_stb))
      else $error("Word without clock edge");
   a_post_legal: assert property (@(posedge clk) disable iff (reset) // RULE14
      trig_fire |=> remain_r >= dwc_pkg::POST_MIN_32 && remain_r[4:0] == 5'h00)
      else $error("Post count off grid");
   a_done_stops: assert property (@(posedge clk) disable iff (reset) // RULE17
      cap_done && !arm |=> (state_r == ST_IDLE) && done_r && stat_r[dwc_pkg::IRQ_DONE])
      else $error("Capture did not finish");
   a_dma_beat: assert property (@(posedge clk) disable iff (reset) // RULE13
      dma_beat |=> !dma_req && dma_addr == $past(dma_addr) + 32'h00000004)
      else $error("DMA beat not advanced");
endmodule

// ==== dwc_user_model.sv ====
// ====
// User logic: sample clock, counting data bus, trigger line
module dwc_user_model (
   // Bench control
   input wire logic run,
   input wire logic trig_lvl,
   // Pins toward the capture block
   output logic cap_clk,
   output logic [31:0] cap_data,
   output logic cap_trig
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] cnt = 16'h0000; // Sample counter, one step per clock
   // 200 ns clock, phased off the system clock edges so neither cap_clk nor cap_data moves on a sampling edge
   initial begin
      cap_clk = 1'b0;
      #10;
      forever begin
         #100;
         // Parked low while stopped; a high phase always completes
         if (cap_clk) cap_clk = 1'b0;
         else if (run) cap_clk = 1'b1;
      end
   end
   // Data moves mid-high so both edges see it settled
   always @(posedge cap_clk) begin
      #50 cnt = cnt + 16'h0001;
   end
   assign cap_data = {2{cnt}};
   assign cap_trig = trig_lvl;
endmodule

// ==== digital_word_capture_tb.sv ====
module digital_word_capture_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // Pins and bench state
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic dma_ack = 1'b0;
   logic run = 1'b0; // Far-side clock enable
   logic trig_lvl = 1'b0; // Far-side trigger level
   logic cap_clk, cap_trig, trig_out, irq, dma_req;
   logic [31:0] reg_rdata, cap_data, dma_addr, dma_wdata, t, w0, w1, v;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
      $display("ERROR %s exp %h got %h", n, e, g); end end
   dwc_capture dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_data(cap_data),
      .cap_clk(cap_clk), .cap_trig(cap_trig), .trig_out(trig_out), .irq(irq),
      .dma_req(dma_req), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack));
   dwc_user_model u_user (.run(run), .trig_lvl(trig_lvl), .cap_clk(cap_clk),
      .cap_data(cap_data), .cap_trig(cap_trig));
   // ====
   // Register port, one idle cycle between strobes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait on trig_out (0), irq (1) or dma_req (2), sampled on falling edges
   task automatic await(input int sel, input int lim, output int n);
      n = 0;
      while ((sel == 0 ? trig_out : sel == 1 ? irq : dma_req) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   // ====
   // Reset post count, unmapped read, post count per width
   task automatic t_post();
      logic [31:0] mn [3] = '{32'h100, 32'h80, 32'h40};
      logic [31:0] hi [3] = '{32'h180, 32'h1c0, 32'h1e0};
      rd(dwc_pkg::OFF_POST, v);
      `CHK("post rst", 32'h100, v)
      rd(8'h3c, v);
      `CHK("unmapped", 32'h0, v)
      for (int i = 0; i < 3; i++) begin
         wr(dwc_pkg::OFF_CTRL, 32'(i) << 2);
         wr(dwc_pkg::OFF_POST, 32'h10);
         rd(dwc_pkg::OFF_POST, v);
         `CHK("post min", mn[i], v)
         wr(dwc_pkg::OFF_POST, 32'h1ff);
         rd(dwc_pkg::OFF_POST, v);
         `CHK("post step", hi[i], v)
      end
   endtask
   // One capture: arm, long wait, stall if external clock, trigger, done, fetch two words at trigger
   task automatic cap(input logic [31:0] c, input logic ext);
      int n;
      logic [31:0] a;
      wr(dwc_pkg::OFF_CTRL, c);
      run <= ext;
      idle(1000);
      rd(dwc_pkg::OFF_STATUS, a);
      `CHK("armed", 3'b001, a[2:0])
      if (ext) begin
         run <= 1'b0;
         idle(20);
         rd(dwc_pkg::OFF_WR_ADDR, a);
         idle(100);
         rd(dwc_pkg::OFF_WR_ADDR, v);
         `CHK("stopped", a, v)
         run <= 1'b1;
         trig_lvl <= ~trig_lvl;
      end else begin
         wr(dwc_pkg::OFF_CTRL, c & 32'hfffffffe | 32'h2);
      end
      await(0, 20, n);
      `CHK("lag", 1'b1, n <= 8)
      await(1, 5000, n);
      `CHK("done irq", 1'b1, irq)
      rd(dwc_pkg::OFF_INT_STAT, a);
      `CHK("stat", 2'b11, a[1:0])
      rd(dwc_pkg::OFF_TRIG_ADDR, t);
      rd(dwc_pkg::OFF_WR_ADDR, v);
      `CHK("depth", 1'b1, v - t - 32'd64 < 32'd2)
      wr(dwc_pkg::OFF_MEM_ADDR, t);
      rd(dwc_pkg::OFF_MEM_DATA, w0);
      rd(dwc_pkg::OFF_MEM_DATA, w1);
      run <= 1'b0;
   endtask
   // DMA of the two words at the trigger address with a stalling host, interrupt masked
   task automatic t_dma();
      int n;
      wr(dwc_pkg::OFF_INT_MASK, 32'h0);
      wr(dwc_pkg::OFF_DMA_SRC, t);
      wr(dwc_pkg::OFF_DMA_DST, 32'h400);
      wr(dwc_pkg::OFF_DMA_LEN, 32'h2);
      wr(dwc_pkg::OFF_DMA_CTRL, 32'h1);
      for (int k = 0; k < 2; k++) begin
         await(2, 20, n);
         idle(3);
         `CHK("dma req", 1'b1, dma_req)
         `CHK("dma addr", 32'h400 + 32'(k) * 4, dma_addr)
         `CHK("dma data", k ? w1 : w0, dma_wdata)
         dma_ack <= 1'b1;
         @(posedge clk);
         dma_ack <= 1'b0;
         @(posedge clk);
      end
      idle(10);
      `CHK("masked", 1'b0, irq)
      rd(dwc_pkg::OFF_INT_STAT, v);
      `CHK("dma stat", 1'b1, v[2])
      rd(dwc_pkg::OFF_INT_STAT, v);
      `CHK("cleared", 32'h0, v)
   endtask
   // Abort is the only way out of the armed wait besides a trigger
   task automatic t_abort();
      wr(dwc_pkg::OFF_CTRL, 32'h9);
      wr(dwc_pkg::OFF_CTRL, 32'h108);
      rd(dwc_pkg::OFF_STATUS, v);
      `CHK("abort", 32'h0, v)
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run of some 7000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         print_verdict();
      end
   end
   // ====
   // Main sequence
   initial begin
      idle(8);
      reset <= 1'b0;
      idle(4);
      t_post();
      wr(dwc_pkg::OFF_POST, 32'h0);
      wr(dwc_pkg::OFF_INT_MASK, 32'h2);
      cap(32'h91, 1'b1); // 8 bit, external clock and trigger, rising edges
      `CHK("pack8", w0[7:0] + 8'h01, w0[15:8])
      `CHK("pack8 next", w0[31:24] + 8'h01, w1[7:0])
      cap(32'hf5, 1'b1); // 16 bit, falling clock and trigger edges
      `CHK("pack16", w0[15:0] + 16'h0001, w0[31:16])
      cap(32'h09, 1'b0); // 32 bit, internal clock, software trigger
      `CHK("word32", cap_data, w0)
      `CHK("word32 next", cap_data, w1)
      t_dma();
      t_abort();
      print_verdict();
   end
endmodule
